// [design/hm_core.sv]
`timescale 1ns/1ps
module hm_core
  import hm_pkg::*;
#(
  parameter logic [20:0] PULSE_CYCLES = 21'(hm_pkg::PULSE_CYC)
) (
  input  logic       clk,
  input  logic       arst_n,
  input  logic       scl_pin,
  input  logic       sda_pin,
  output logic       sda_drv,
  output logic       sda_oe,
  input  logic [2:0] slave_addr_pins,
  output logic       conv_req,
  output logic [3:0] conv_ch,
  input  logic       conv_done,
  input  logic [9:0] conv_data,
  output logic       alarm_out_n,
  output logic       reset_or_overtemp_out_n,
  input  logic       intrusion_input,
  output logic       intrusion_input_drv,
  output logic       intrusion_input_oe,
  output logic       general_output
);
  // ==========================================
  // reset release and pin synchronisers
  logic [1:0] rs_r;
  logic       rst_n;
  logic [5:0] sy1_r;
  logic [5:0] sy2_r;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rs_r <= 2'b00;
    end else begin
      rs_r <= {rs_r[0], 1'b1};
    end
  end
  assign rst_n = rs_r[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle levels: bus lines high, intrusion low, so no false event after reset
      sy1_r <= 6'h03;
      sy2_r <= 6'h03;
    end else begin
      sy1_r <= {intrusion_input, slave_addr_pins, sda_pin, scl_pin};
      sy2_r <= sy1_r;
    end
  end

  // ==========================================
  // two-wire target
  hm_tst_t    tst_r;
  logic       scl_p_r;
  logic       sda_p_r;
  logic       busy_r;
  logic [2:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] ptr_r;
  logic       rw_r;
  logic       done_r;
  logic       mack_r;
  logic       oe_r;
  logic [7:0] rd_byte;
  hm_wr_t     wr;
  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       addr_hit;

  assign scl_rise  = sy2_r[0] & ~scl_p_r;
  assign scl_fall  = ~sy2_r[0] & scl_p_r;
  assign bus_start = sy2_r[0] & scl_p_r & sda_p_r & ~sy2_r[1];
  assign bus_stop  = sy2_r[0] & scl_p_r & ~sda_p_r & sy2_r[1];
  assign addr_hit  = (sh_r[7:1] == {ADDR_HI, sy2_r[4:2]});
  // open-drain: only pulls low, clock pin is input only
  assign sda_drv = 1'b0;
  assign sda_oe = oe_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_p_r <= sy2_r[0];
      sda_p_r <= sy2_r[1];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tst_r  <= T_IDLE;
      busy_r <= 1'b0;
      cnt_r  <= 3'h0;
      sh_r   <= 8'h00;
      ptr_r  <= 8'h00;
      rw_r   <= 1'b0;
      done_r <= 1'b0;
      mack_r <= 1'b0;
      oe_r   <= 1'b0;
    end else if (bus_start) begin
      tst_r  <= T_ADDR;
      busy_r <= 1'b1;
      cnt_r  <= 3'h0;
      done_r <= 1'b0;
      oe_r   <= 1'b0;
    end else if (bus_stop) begin
      tst_r  <= T_IDLE;
      busy_r <= 1'b0;
      oe_r   <= 1'b0;
    end else begin
      case (tst_r)
        T_ADDR, T_PTR, T_WDATA: begin
          if (scl_rise) begin
            sh_r   <= {sh_r[6:0], sy2_r[1]};
            cnt_r  <= cnt_r + 3'h1;
            done_r <= (cnt_r == 3'h7);
          end else if (scl_fall && done_r) begin
            done_r <= 1'b0;
            cnt_r  <= 3'h0;
            if (tst_r == T_ADDR) begin
              if (addr_hit) begin
                rw_r  <= sh_r[0];
                oe_r  <= 1'b1;
                tst_r <= T_AACK;
              end else begin
                tst_r <= T_IDLE;
              end
            end else if (tst_r == T_PTR) begin
              ptr_r <= sh_r;
              oe_r  <= 1'b1;
              tst_r <= T_PACK;
            end else begin
              oe_r  <= 1'b1;
              tst_r <= T_WACK;
            end
          end
        end
        T_AACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              sh_r  <= rd_byte;
              oe_r  <= ~rd_byte[7];
              cnt_r <= 3'h0;
              tst_r <= T_RDATA;
            end else begin
              oe_r  <= 1'b0;
              tst_r <= T_PTR;
            end
          end
        end
        T_PACK, T_WACK: begin
          if (scl_fall) begin
            oe_r  <= 1'b0;
            tst_r <= T_WDATA;
          end
        end
        T_RDATA: begin
          if (scl_fall) begin
            if (cnt_r == 3'h7) begin
              oe_r  <= 1'b0;
              tst_r <= T_RACK;
            end else begin
              sh_r  <= {sh_r[6:0], 1'b0};
              oe_r  <= ~sh_r[6];
              cnt_r <= cnt_r + 3'h1;
            end
          end
        end
        T_RACK: begin
          if (scl_rise) begin
            mack_r <= ~sy2_r[1];
          end else if (scl_fall) begin
            if (mack_r) begin
              sh_r  <= rd_byte;
              oe_r  <= ~rd_byte[7];
              cnt_r <= 3'h0;
              tst_r <= T_RDATA;
            end else begin
              tst_r <= T_IDLE;
            end
          end
        end
        default: tst_r <= T_IDLE;
      endcase
    end
  end

  always_comb begin
    wr.en   = (tst_r == T_WDATA) && scl_fall && done_r;
    wr.addr = ptr_r;
    wr.data = sh_r;
  end

  // ==========================================
  // control registers
  logic [7:0]  cfg_r;
  logic [15:0] st_r;
  logic [15:0] msk_r;
  logic [7:0]  div_r;
  logic [7:0]  osc_r;
  logic [7:0]  rate_r;
  logic [7:0]  dis_r;
  logic        sinit_r;
  logic [15:0] st_set;
  logic        running;

  assign running = cfg_r[CFG_START] & ~cfg_r[CFG_CLR];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sinit_r <= 1'b0;
    end else begin
      sinit_r <= wr.en && (wr.addr == REG_CFG) && wr.data[CFG_INIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RST;
    end else if (sinit_r) begin
      cfg_r <= CFG_RST;
    end else if (wr.en && wr.addr == REG_CFG) begin
      // init bit is never stored, so it reads back as zero
      cfg_r <= {1'b0, wr.data[6:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r  <= DIV_RST;
      osc_r  <= OSC_RST;
      rate_r <= ZERO_RST;
      dis_r  <= ZERO_RST;
      msk_r  <= {ZERO_RST, ZERO_RST};
    end else if (sinit_r) begin
      div_r  <= DIV_RST;
      osc_r  <= OSC_RST;
      rate_r <= ZERO_RST;
      dis_r  <= ZERO_RST;
      msk_r  <= {ZERO_RST, ZERO_RST};
    end else if (wr.en) begin
      case (wr.addr)
        REG_DIV:  div_r         <= wr.data;
        REG_OSC:  osc_r         <= wr.data;
        REG_RATE: rate_r        <= wr.data;
        REG_DIS:  dis_r         <= wr.data;
        REG_MSK1: msk_r[7:0]    <= wr.data;
        REG_MSK2: msk_r[15:8]   <= wr.data;
        default:  dis_r         <= dis_r;
      endcase
    end
  end

  // status: write one to clear, a new violation wins over the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= {ZERO_RST, ZERO_RST};
    end else if (sinit_r) begin
      st_r <= {ZERO_RST, ZERO_RST};
    end else begin
      st_r <= (st_r & ~{(wr.en && wr.addr == REG_ST2) ? wr.data : 8'h00,
                        (wr.en && wr.addr == REG_ST1) ? wr.data : 8'h00}) | st_set;
    end
  end

  // ==========================================
  // value ram and sequencer
  logic [7:0] ram_r [0:31];
  hm_mst_t    mst_r;
  logic [3:0] ch_r;
  logic [9:0] res_r;
  logic [7:0] res8;
  logic [4:0] slot;
  logic       ch_off;
  logic       commit;

  // temperature goes to its own slot, the rest follow in order
  assign slot   = (ch_r == 4'h0) ? SLOT_TEMP :
                  (ch_r <= 4'h7) ? 5'(ch_r - 4'h1) : 5'(ch_r);
  assign ch_off = (ch_r == 4'h0) ? dis_r[DIS_TEMP] :
                  (ch_r <= 4'h7) ? dis_r[3'(ch_r - 4'h1)] : 1'b0;
  // 10-bit code, top eight bits kept in ram; fans count in low byte
  assign res8   = (ch_r >= 4'h8) ? res_r[7:0] : res_r[9:2];
  assign commit = (mst_r == M_HOLD) && !busy_r;
  assign conv_req = (mst_r == M_CONV);
  assign conv_ch  = ch_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mst_r <= M_IDLE;
      ch_r  <= 4'h0;
      res_r <= 10'h000;
    end else begin
      case (mst_r)
        M_IDLE: begin
          if (running) begin
            if (ch_off) begin
              ch_r <= (ch_r == CH_LAST) ? 4'h0 : ch_r + 4'h1;
            end else begin
              mst_r <= M_CONV;
            end
          end
        end
        M_CONV: begin
          if (conv_done) begin
            res_r <= conv_data;
            mst_r <= M_HOLD;
          end
        end
        M_HOLD: begin
          if (commit) begin
            ch_r  <= (ch_r == CH_LAST) ? 4'h0 : ch_r + 4'h1;
            mst_r <= M_IDLE;
          end
        end
        default: mst_r <= M_IDLE;
      endcase
    end
  end

  // no reset: results and limits survive every init
  always_ff @(posedge clk) begin
    if (wr.en && wr.addr[7:5] == RAM_PAGE) begin
      ram_r[wr.addr[4:0]] <= wr.data;
    end else if (commit) begin
      ram_r[slot] <= res8;
    end
  end

  always_comb begin
    st_set = 16'h0000;
    if (commit) begin
      if (ch_r == 4'h0) begin
        st_set[ST2_TEMP] = $signed(res8) > $signed(ram_r[LIM_TEMP]);
      end else if (ch_r <= 4'h7) begin
        st_set[3'(ch_r - 4'h1)] = (res8 > ram_r[5'(LIM_IN_HI + {ch_r - 4'h1, 1'b0})]) ||
                                  (res8 < ram_r[5'(LIM_IN_LO + {ch_r - 4'h1, 1'b0})]);
      end else if (ch_r == 4'h8) begin
        st_set[ST2_FAN1] = res8 > ram_r[LIM_FAN1];
      end else begin
        st_set[ST2_FAN2] = res8 > ram_r[LIM_FAN2];
      end
    end
    st_set[ST2_CHAS] = sy2_r[5];
  end

  always_comb begin
    case (ptr_r)
      REG_CFG:  rd_byte = cfg_r;
      REG_ST1:  rd_byte = st_r[7:0];
      REG_ST2:  rd_byte = st_r[15:8];
      REG_MSK1: rd_byte = msk_r[7:0];
      REG_MSK2: rd_byte = msk_r[15:8];
      REG_DIV:  rd_byte = div_r;
      REG_OSC:  rd_byte = osc_r;
      REG_RATE: rd_byte = rate_r;
      REG_DIS:  rd_byte = dis_r;
      REG_MFR:  rd_byte = MFR_ID;
      REG_REV:  rd_byte = REV_ID;
      default:  rd_byte = (ptr_r[7:5] == RAM_PAGE) ? ram_r[ptr_r[4:0]] : 8'h00;
    endcase
  end

  // ==========================================
  // output pins
  logic alarm_n_r;
  logic genout_r;
  logic rstp_go;
  logic chas_go;
  logic rstp_act;
  logic chas_act;

  assign rstp_go = wr.en && wr.addr == REG_CFG && wr.data[CFG_RSTP] &&
                   !div_r[DIV_OSSEL] && div_r[DIV_RSTEN];
  assign chas_go = wr.en && wr.addr == REG_CFG && wr.data[CFG_CHAS];

  hm_pulse #(.CYCLES(PULSE_CYCLES)) u_rstp (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (rstp_go),
    .active (rstp_act)
  );

  hm_pulse #(.CYCLES(PULSE_CYCLES)) u_chas (
    .clk    (clk),
    .rst_n  (rst_n),
    .start  (chas_go),
    .active (chas_act)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_n_r <= 1'b1;
      genout_r  <= 1'b0;
    end else begin
      alarm_n_r <= ~(cfg_r[CFG_INT_EN] & ~cfg_r[CFG_CLR] & |(st_r & ~msk_r));
      genout_r  <= cfg_r[CFG_GENOUT];
    end
  end

  assign alarm_out_n             = alarm_n_r;
  assign general_output          = genout_r;
  assign reset_or_overtemp_out_n = ~rstp_act;
  assign intrusion_input_drv     = 1'b0;
  assign intrusion_input_oe      = chas_act;

  // ==========================================
  // checks
  AST_ADDR_MISS: assert property (@(posedge clk) disable iff (!rst_n)
    (tst_r == T_ADDR && scl_fall && done_r && !addr_hit && !bus_start && !bus_stop) |=> !sda_oe)
    else $error("acked a foreign address");
  AST_INIT_RESTORE: assert property (@(posedge clk) disable iff (!rst_n)
    (wr.en && wr.addr == REG_CFG && wr.data[CFG_INIT]) |=> ##1 (cfg_r == CFG_RST && div_r == DIV_RST))
    else $error("soft init did not restore defaults");
  AST_INIT_SELFCLR: assert property (@(posedge clk) disable iff (!rst_n)
    sinit_r |=> (!sinit_r && !cfg_r[CFG_INIT]))
    else $error("soft init bit stuck");
  AST_SHUTDOWN: assert property (@(posedge clk) disable iff (!rst_n)
    (!cfg_r[CFG_START] && mst_r == M_IDLE) |=> (mst_r == M_IDLE && !conv_req))
    else $error("conversion started while stopped");
  AST_ALARM_GATE: assert property (@(posedge clk) disable iff (!rst_n)
    !cfg_r[CFG_INT_EN] |=> alarm_out_n)
    else $error("alarm active while disabled");
  // status may still gain bits while clear is high, and loses none unless a one is written to it or a soft init runs
  AST_CLEAR_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    (cfg_r[CFG_CLR] && !wr.en && !sinit_r) |=> (alarm_out_n && (($past(st_r) & ~st_r) == 16'h0000)))
    else $error("alarm clear did not hold");
  AST_RST_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    rstp_go |=> !reset_or_overtemp_out_n [*8])
    else $error("reset pulse missing");
  AST_CHASSIS: assert property (@(posedge clk) disable iff (!rst_n)
    chas_go |=> (intrusion_input_oe && !intrusion_input_drv) [*8])
    else $error("intrusion pin not driven low");
  AST_GEN_OUT: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(cfg_r[CFG_GENOUT]) |=> general_output)
    else $error("general output did not follow");
  AST_DEFER: assert property (@(posedge clk) disable iff (!rst_n)
    (mst_r == M_HOLD && busy_r) |=> (mst_r == M_HOLD && $stable(ch_r)))
    else $error("result committed during transaction");
endmodule

// [common/hm_pkg.sv]
package hm_pkg;
  // ==========================================
  // register map
  localparam logic [7:0] REG_CFG  = 8'h00;
  localparam logic [7:0] REG_ST1  = 8'h01;
  localparam logic [7:0] REG_ST2  = 8'h02;
  localparam logic [7:0] REG_MSK1 = 8'h03;
  localparam logic [7:0] REG_MSK2 = 8'h04;
  localparam logic [7:0] REG_DIV  = 8'h05;
  localparam logic [7:0] REG_OSC  = 8'h06;
  localparam logic [7:0] REG_RATE = 8'h07;
  localparam logic [7:0] REG_DIS  = 8'h08;
  localparam logic [7:0] REG_MFR  = 8'h3E;
  localparam logic [7:0] REG_REV  = 8'h3F;
  localparam logic [2:0] RAM_PAGE = 3'h1;
  // ==========================================
  // value ram slots (index = offset - 20h)
  localparam logic [4:0] SLOT_TEMP   = 5'h07;
  localparam logic [4:0] LIM_IN_HI   = 5'h0A;
  localparam logic [4:0] LIM_IN_LO   = 5'h0B;
  localparam logic [4:0] LIM_TEMP    = 5'h18;
  localparam logic [4:0] LIM_FAN1    = 5'h1C;
  localparam logic [4:0] LIM_FAN2    = 5'h1D;
  // ==========================================
  // reset values
  localparam logic [7:0] CFG_RST  = 8'h08;
  localparam logic [7:0] DIV_RST  = 8'h14;
  localparam logic [7:0] OSC_RST  = 8'h01;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // arbitrary identity values
  localparam logic [7:0] MFR_ID   = 8'h5A;
  localparam logic [7:0] REV_ID   = 8'h01;
  // ==========================================
  // field positions
  localparam int CFG_START  = 0;
  localparam int CFG_INT_EN = 1;
  localparam int CFG_CLR    = 3;
  localparam int CFG_RSTP   = 4;
  localparam int CFG_CHAS   = 5;
  localparam int CFG_GENOUT = 6;
  localparam int CFG_INIT   = 7;
  localparam int DIV_OSSEL  = 6;
  localparam int DIV_RSTEN  = 7;
  localparam int DIS_TEMP   = 7;
  localparam int ST2_TEMP   = 8;
  localparam int ST2_FAN1   = 9;
  localparam int ST2_FAN2   = 10;
  localparam int ST2_CHAS   = 11;
  localparam logic [3:0] ADDR_HI  = 4'b0101;
  localparam logic [3:0] CH_LAST  = 4'h9;
  // ==========================================
  // timing
  localparam longint CLK_HZ     = 125000000;
  localparam longint PULSE_MS   = 10;
  localparam longint PULSE_CYC  = (PULSE_MS * CLK_HZ) / 1000;
  localparam int     PULSE_W    = 21;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } hm_wr_t;

  typedef enum logic [3:0] {
    T_IDLE, T_ADDR, T_AACK, T_PTR, T_PACK, T_WDATA, T_WACK, T_RDATA, T_RACK
  } hm_tst_t;

  typedef enum logic [1:0] {M_IDLE, M_CONV, M_HOLD} hm_mst_t;
endpackage

// [design/hm_pulse.sv]
`timescale 1ns/1ps
module hm_pulse #(
  parameter logic [20:0] CYCLES = 21'h1
) (
  input  logic clk,
  input  logic rst_n,
  input  logic start,
  output logic active
);
  logic [20:0] cnt_r;

  // a retrigger restarts the full width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 21'h0_0000;
    end else if (start) begin
      cnt_r <= CYCLES;
    end else if (cnt_r != 21'h0_0000) begin
      cnt_r <= cnt_r - 21'h0_0001;
    end
  end

  assign active = (cnt_r != 21'h0_0000);
endmodule

// [tb/hm_host.sv]
`timescale 1ns/1ps
module hm_host #(
  parameter int H = 5
) (
  input  wire logic       clk,
  input  wire logic       sda,
  input  wire logic [6:0] dev_addr,
  output logic            scl,
  output logic            sda_h
);
  // ==========================================
  // bus host; lines move just after a clk edge
  // five clk per half period: an 80 ns link clock; the target sees edges three clk late
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bstart();
    sda_h <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(H);
    sda_h <= 1'b0;
    tick(H);
    scl <= 1'b0;
    tick(4);
  endtask
  task automatic bstop();
    sda_h <= 1'b0;
    tick(H - 4);
    scl <= 1'b1;
    tick(H);
    sda_h <= 1'b1;
    tick(H);
  endtask
  // msb first; ack slot always released, so a read byte ends in nack
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_h <= (i == 0) ? 1'b1 : d[i - 1];
      tick(H - 4);
      scl <= 1'b1;
      tick(H);
      if (i > 0) q[i - 1] = sda;
      else ack = ~sda;
      scl <= 1'b0;
      tick(4);
    end
  endtask
  task automatic wr_reg(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    logic       a2;
    bstart();
    xbyte({dev_addr, 1'b0}, q, a0);
    xbyte(p, q, a1);
    xbyte(d, q, a2);
    bstop();
    ok = a0 & a1 & a2;
  endtask
  task automatic rd_cur(output logic [7:0] d, output logic ok);
    logic [7:0] q;
    bstart();
    xbyte({dev_addr, 1'b1}, q, ok);
    xbyte(8'hFF, d, q[0]);
    bstop();
  endtask
  task automatic rd_reg(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic       a0;
    logic       a1;
    bstart();
    xbyte({dev_addr, 1'b0}, q, a0);
    xbyte(p, q, a1);
    rd_cur(d, ok);
    ok = ok & a0 & a1;
  endtask
endmodule

// [tb/hm_core_tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module hm_core_tb;
  import hm_pkg::*;
  localparam int PW = 50;
  localparam logic [15:0] RT [11] = '{{REG_CFG, CFG_RST}, {REG_ST1, ZERO_RST}, {REG_ST2, ZERO_RST},
    {REG_MSK1, ZERO_RST}, {REG_MSK2, ZERO_RST}, {REG_DIV, DIV_RST}, {REG_OSC, OSC_RST},
    {REG_RATE, ZERO_RST}, {REG_DIS, ZERO_RST}, {REG_MFR, MFR_ID}, {REG_REV, REV_ID}};
  localparam logic [15:0] LT [7] = '{{REG_DIS, 8'hFE}, {8'h2A, 8'h00}, {8'h2B, 8'h00},
    {8'h3C, 8'hFF}, {8'h3D, 8'hFF}, {REG_ST1, 8'hFF}, {REG_ST2, 8'hFF}};
  logic       clk;
  logic       arst_n;
  logic       scl;
  logic       sda_h;
  wire        sda;
  logic       sda_oe;
  logic [2:0] pins;
  logic [6:0] haddr;
  logic       conv_req;
  logic [3:0] conv_ch;
  logic       conv_done;
  logic [9:0] conv_data;
  logic       alarm_n;
  logic       rst_out_n;
  logic       intr_ext;
  logic       intr_oe;
  wire        intr_lvl;
  logic       gen_out;
  logic [2:0] cbusy;
  logic [3:0] log_q[$];
  int         cyc;
  int         cnt_rst;
  int         cnt_chas;
  int         n_errors;
  int         compares;
  // ==========================================
  // wires: both lines pulled up, pulled low by whoever enables
  assign sda = sda_h & ~sda_oe;
  assign intr_lvl = intr_ext & ~intr_oe;
  hm_core #(.PULSE_CYCLES(21'(PW))) hm_core_i (
    .clk(clk), .arst_n(arst_n), .scl_pin(scl), .sda_pin(sda), .sda_drv(), .sda_oe(sda_oe),
    .slave_addr_pins(pins), .conv_req(conv_req), .conv_ch(conv_ch), .conv_done(conv_done),
    .conv_data(conv_data), .alarm_out_n(alarm_n), .reset_or_overtemp_out_n(rst_out_n),
    .intrusion_input(intr_lvl), .intrusion_input_drv(), .intrusion_input_oe(intr_oe),
    .general_output(gen_out));
  hm_host hm_host_i (.clk(clk), .sda(sda), .dev_addr(haddr), .scl(scl), .sda_h(sda_h));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================
  // converter stand-in; result tracks the channel so slots are predictable
  function automatic logic [9:0] cval(input logic [3:0] ch);
    return 10'(ch) * 10'h032 + 10'h003;
  endfunction
  always @(posedge clk) begin
    conv_done <= 1'b0;
    if (cbusy != 3'h0) cbusy <= cbusy - 3'h1;
    if (cbusy == 3'h1) begin
      conv_done <= 1'b1;
      conv_data <= cval(conv_ch);
    end else if (cbusy == 3'h0 && conv_req && !conv_done) cbusy <= 3'h6;
    if (conv_done) log_q.push_back(conv_ch);
  end
  always @(posedge clk) begin
    cyc++;
    if (rst_out_n === 1'b0) cnt_rst++;
    if (intr_oe === 1'b1) cnt_chas++;
    if (cyc == 60000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] v);
    logic ok;
    hm_host_i.wr_reg(p, v, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic rchk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    hm_host_i.rd_reg(p, d, ok);
    `CHK(ok, 1'b1)
    `CHK(d, e)
  endtask
  task automatic wrap_up();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    logic [7:0] d;
    logic       ok;
    int         n;
    logic [9:0] v;
    arst_n = 1'b0;
    pins = 3'h7;
    haddr = {ADDR_HI, 3'h7};
    intr_ext = 1'b0;
    conv_done = 1'b0;
    conv_data = 10'h000;
    cbusy = 3'h0;
    tick(3);
    arst_n <= 1'b1;
    tick(10);
    for (int i = 0; i < 11; i++) rchk(RT[i][15:8], RT[i][7:0]);
    `CHK(conv_req, 1'b0)
    `CHK(alarm_n, 1'b1)
    for (int k = 0; k < 8; k++) begin
      pins <= 3'(k);
      haddr <= {ADDR_HI, 3'(k)};
      tick(10);
      wr(REG_MSK1, 8'(k));
      hm_host_i.rd_cur(d, ok);
      `CHK(d, 8'(k))
      haddr <= {ADDR_HI, 3'(k + 1)};
      tick(1);
      hm_host_i.wr_reg(REG_MSK1, 8'hEE, ok);
      `CHK(ok, 1'b0)
    end
    haddr <= {ADDR_HI, 3'h7};
    rchk(REG_MSK1, 8'h07);
    wr(REG_CFG, 8'h18);
    tick(100);
    `CHK(cnt_rst, 0)
    wr(REG_CFG, 8'h28);
    tick(100);
    `CHK(cnt_chas, PW)
    wr(REG_DIV, 8'h80);
    wr(REG_CFG, 8'h18);
    tick(100);
    `CHK(cnt_rst, PW)
    wr(REG_CFG, 8'h48);
    `CHK(gen_out, 1'b1)
    wr(8'h2A, 8'h77);
    wr(REG_CFG, 8'h80);
    rchk(REG_CFG, CFG_RST);
    rchk(REG_MSK1, ZERO_RST);
    rchk(REG_DIV, DIV_RST);
    rchk(8'h2A, 8'h77);
    `CHK(gen_out, 1'b0)
    `CHK(conv_req, 1'b0)
    wr(REG_CFG, 8'h01);
    for (int i = 0; i < 5000 && log_q.size() < 10; i++) tick(1);
    `CHK(log_q.size() >= 10, 1'b1)
    for (int i = 0; i < 10; i++) `CHK(log_q[i], 4'(i))
    `CHK(alarm_n, 1'b1)
    for (int c = 0; c < 10; c++) begin
      v = cval(4'(c));
      rchk((c == 0) ? 8'h27 : (c < 8) ? 8'(8'h1F + c) : 8'(8'h20 + c), (c < 8) ? v[9:2] : v[7:0]);
    end
    wr(REG_CFG, 8'h00);
    tick(30);
    n = log_q.size();
    tick(200);
    `CHK(log_q.size(), n)
    for (int i = 0; i < 7; i++) wr(LT[i][15:8], LT[i][7:0]);
    wr(REG_CFG, 8'h03);
    for (int i = 0; i < 3000 && alarm_n !== 1'b0; i++) tick(1);
    `CHK(alarm_n, 1'b0)
    rchk(REG_ST1, 8'h01);
    rchk(REG_ST2, ZERO_RST);
    wr(REG_CFG, 8'h0B);
    `CHK(alarm_n, 1'b1)
    rchk(REG_ST1, 8'h01);
    intr_ext <= 1'b1;
    tick(10);
    intr_ext <= 1'b0;
    rchk(REG_ST2, 8'h08);
    arst_n <= 1'b0;
    tick(7);
    arst_n <= 1'b1;
    tick(10);
    rchk(REG_CFG, CFG_RST);
    rchk(REG_ST1, ZERO_RST);
    rchk(REG_DIS, ZERO_RST);
    `CHK(alarm_n, 1'b1)
    wrap_up();
  end
endmodule
